// [common/timer_flags_cfg.svh]
// Purpose: constants of the timer status flag block
// Assumes: 32-bit Avalon-MM data, byte addresses, word-aligned registers
// Notes: types live in timer_flags_pkg
`ifndef TIMER_FLAGS_CFG_SVH
`define TIMER_FLAGS_CFG_SVH
`define OFS_CTRL    8'h00
`define OFS_ENABLE  8'h0C
`define OFS_FLAGS   8'h10
`define OFS_EVGEN   8'h14
`define B_UPD       0
`define B_CH_LO     1
`define B_CH_HI     4
`define B_TRIG      6
`define B_OVC_LO    9
`define B_OVC_HI    12
`define B_UPDATE_DISABLE      1
`define B_URS       2
`define B_UG        0
`define B_TG        6
`define ENABLE_MASK 16'h005F
`define FLAGS_RST   16'h0000
`define RDATA_RST   32'h0000_0000
`endif

// [common/timer_flags_pkg.sv]
// Purpose: types of the timer status flag block
// Assumes: slave mode codes as driven by the slave-mode controller
// Notes: constants live in timer_flags_cfg.svh
package timer_flags_pkg;
  typedef enum logic [2:0] {
    SM_INTERNAL = 3'h0,
    SM_RESET    = 3'h4,
    SM_GATED    = 3'h5,
    SM_TRIGGER  = 3'h6,
    SM_EXTCLK   = 3'h7
  } slave_mode_t;

  // state of the top module apart from the flags, which the flag_bit instances hold
  typedef struct packed {
    logic        waitReg;
    logic [31:0] rdReg;
    logic        irqReg;
    logic        trigPrev;
    logic        update_disable;
    logic        update_request_source;
    logic [15:0] enable;
    logic        ugPulse;
    logic        tgPulse;
  } core_state_t;
endpackage

// [core/flag_bit.sv]
// Purpose: group of sticky flags, set by hardware, cleared by a strobe
// Assumes: set and clear are one-cycle strobes in clk_sys
// Notes: set wins over clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module flag_bit #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  // set and clear strobes
  input  wire logic [WIDTH-1:0] setIn,
  input  wire logic [WIDTH-1:0] clrIn,
  // flag state
  output logic      [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] flag;
  } flag_state_t;

  flag_state_t st_reg;
  flag_state_t st_next;

  // set beats clear so no event is lost
  always_comb
  begin
    st_next.flag = setIn | (st_reg.flag & ~clrIn);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      st_reg.flag <= '0;
    else
      st_reg <= st_next;
  end

  assign q = st_reg.flag;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_set_wins: assert property ((setIn & clrIn) != '0 |=> (q & $past(setIn)) == $past(setIn))
    else $error("flag cleared while set was pending");
  a_only_set: assert property (1'b1 |=> ((q & ~$past(q)) & ~$past(setIn)) == '0)
    else $error("flag rose without a set strobe");
endmodule
`default_nettype wire

// [core/timer_status_flags.sv]
// Purpose: status flags of a 16-bit general-purpose timer with Avalon-MM access
// Assumes: event strobes are one-cycle pulses synchronous to clk_sys
// Notes: flags clear on zero write; capture read clears an input channel flag
`timescale 1ns/1ps
`default_nettype none
`include "timer_flags_cfg.svh"
module timer_status_flags #(
  parameter int NUM_CH = 4
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  // avalon-mm slave
  input  wire logic [7:0]        address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  // slave-mode and counter events
  input  wire logic [2:0]        slaveMode,
  input  wire logic              trigInput,
  input  wire logic              repWrap,
  input  wire logic              swReinit,
  input  wire logic              trigReinit,
  input  wire logic              centerAligned,
  // channel events
  input  wire logic [NUM_CH-1:0] chInputMode,
  input  wire logic [NUM_CH-1:0] cmpMatch,
  input  wire logic [NUM_CH-1:0] captureEvt,
  input  wire logic [NUM_CH-1:0] captureRead,
  // requests out
  output logic                   irq,
  output logic                   updateGenerate,
  output logic                   triggerGenerate
);
  timer_flags_pkg::core_state_t st_reg;
  timer_flags_pkg::core_state_t st_next;

  logic              acceptWr;
  logic [15:0]       laneMask;
  logic [15:0]       zeroWr;
  logic [15:0]       flagVec;
  logic              trigEdge;
  logic              isGated;
  logic              updSet;
  logic              trigSet;
  logic [NUM_CH-1:0] chSet;
  logic [NUM_CH-1:0] chClr;
  logic [NUM_CH-1:0] ovcSet;
  logic              updFlag;
  logic              trigFlag;
  logic [NUM_CH-1:0] chFlag;
  logic [NUM_CH-1:0] ovcFlag;

  // a write takes effect only at the edge that sees waitrequest low
  assign acceptWr = write & ~st_reg.waitReg;
  assign laneMask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
  assign zeroWr   = (acceptWr && address == `OFS_FLAGS) ?
                    (~writedata[15:0] & laneMask) : `FLAGS_RST;

  // trigger edge: rising normally, either edge when gated
  assign isGated  = (slaveMode == timer_flags_pkg::SM_GATED);
  assign trigEdge = isGated ? (trigInput ^ st_reg.trigPrev)
                            : (trigInput & ~st_reg.trigPrev);
  assign trigSet  = trigEdge | st_reg.tgPulse;

  // update sources, request source only gates the software and trigger ones
  assign updSet = ~st_reg.update_disable & (repWrap
                  | (~st_reg.update_request_source & (st_reg.ugPulse | swReinit
                  | trigReinit)));

  // compare matches are ignored in center-aligned counting
  assign chSet  = (cmpMatch & ~chInputMode & {NUM_CH{~centerAligned}})
                | (captureEvt & chInputMode);
  assign chClr  = zeroWr[`B_CH_HI:`B_CH_LO] | (captureRead & chInputMode);
  // overcapture only exists for input channels
  assign ovcSet = captureEvt & chInputMode & chFlag;

  // sticky flag groups
  flag_bit #(.WIDTH(1)) uUpd (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .setIn   (updSet),
    .clrIn   (zeroWr[`B_UPD]),
    .q       (updFlag)
  );

  flag_bit #(.WIDTH(1)) uTrig (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .setIn   (trigSet),
    .clrIn   (zeroWr[`B_TRIG]),
    .q       (trigFlag)
  );

  flag_bit #(.WIDTH(NUM_CH)) uCh (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .setIn   (chSet),
    .clrIn   (chClr),
    .q       (chFlag)
  );

  flag_bit #(.WIDTH(NUM_CH)) uOvc (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .setIn   (ovcSet),
    .clrIn   (zeroWr[`B_OVC_HI:`B_OVC_LO]),
    .q       (ovcFlag)
  );

  // flag register image, unused positions stay zero
  always_comb
  begin
    flagVec                      = `FLAGS_RST;
    flagVec[`B_UPD]              = updFlag;
    flagVec[`B_CH_HI:`B_CH_LO]   = chFlag;
    flagVec[`B_TRIG]             = trigFlag;
    flagVec[`B_OVC_HI:`B_OVC_LO] = ovcFlag;
  end

  // next state: bus handshake, read capture, control writes, pulses
  always_comb
  begin
    st_next          = st_reg;
    st_next.waitReg  = ~((read | write) & st_reg.waitReg);
    st_next.trigPrev = trigInput;
    st_next.ugPulse  = 1'b0;
    st_next.tgPulse  = 1'b0;
    // irq lags the flag by one cycle, kept so that irq is a flop
    st_next.irqReg   = |(flagVec & st_reg.enable);
    if (read && st_reg.waitReg)
    begin
      st_next.rdReg = `RDATA_RST;
      unique case (address)
        `OFS_CTRL:
        begin
          st_next.rdReg[`B_UPDATE_DISABLE] = st_reg.update_disable;
          st_next.rdReg[`B_URS]  = st_reg.update_request_source;
        end
        `OFS_ENABLE: st_next.rdReg[15:0] = st_reg.enable;
        `OFS_FLAGS:  st_next.rdReg[15:0] = flagVec;
        default:     st_next.rdReg = `RDATA_RST;
      endcase
    end
    if (acceptWr)
    begin
      unique case (address)
        `OFS_CTRL:
        begin
          if (byteenable[0])
          begin
            st_next.update_disable = writedata[`B_UPDATE_DISABLE];
            st_next.update_request_source  = writedata[`B_URS];
          end
        end
        `OFS_ENABLE:
        begin
          st_next.enable = (st_reg.enable & ~laneMask)
                         | (writedata[15:0] & laneMask & `ENABLE_MASK);
        end
        `OFS_EVGEN:
        begin
          if (byteenable[0])
          begin
            st_next.ugPulse = writedata[`B_UG];
            st_next.tgPulse = writedata[`B_TG];
          end
        end
        default: st_next.ugPulse = 1'b0;
      endcase
    end
  end

  // single state register; trigger history is primed to avoid a false edge
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      st_reg          <= '0;
      st_reg.waitReg  <= 1'b1;
      st_reg.trigPrev <= trigInput;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign readdata        = st_reg.rdReg;
  assign waitrequest     = st_reg.waitReg;
  assign irq             = st_reg.irqReg;
  assign updateGenerate  = st_reg.ugPulse;
  assign triggerGenerate = st_reg.tgPulse;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_req_wait;
    (read || write) && waitrequest;
  endsequence

  sequence s_clear_upd;
    write && !waitrequest && address == `OFS_FLAGS
      && byteenable[0] && !writedata[`B_UPD];
  endsequence

  a_bus_answer: assert property (s_req_wait |=> !waitrequest)
    else $error("bus request not answered after one wait cycle");
  a_reserved_zero: assert property (read && !waitrequest && address == `OFS_FLAGS
    |-> readdata[15:13] == 3'h0 && readdata[8:7] == 2'h0 && !readdata[5])
    else $error("reserved flag bits read nonzero");
  a_ovc_set: assert property (captureEvt[0] && chInputMode[0] && chFlag[0]
    |=> ovcFlag[0])
    else $error("overcapture not flagged");
  a_ovc_output: assert property (!chInputMode[0] && !ovcFlag[0]
    && !(write && address == `OFS_FLAGS) |=> !ovcFlag[0])
    else $error("overcapture set in output compare");
  a_upd_clear: assert property (s_clear_upd ##0 !updSet |=> !updFlag)
    else $error("zero write did not clear update flag");
  a_trig_gated: assert property (isGated && $fell(trigInput) |=> trigFlag)
    else $error("falling edge in gated mode not flagged");
  a_cmp_center: assert property (centerAligned && !chInputMode[1] && !chFlag[1]
    |=> !chFlag[1])
    else $error("compare flag set in center-aligned mode");
  a_cap_read: assert property (captureRead[2] && chInputMode[2] && !captureEvt[2]
    |=> !chFlag[2])
    else $error("capture read did not clear channel flag");
  a_upd_disable: assert property (st_reg.update_disable && !updFlag
    |=> !updFlag)
    else $error("update flag set while updates disabled");
  a_upd_soft: assert property (!st_reg.update_disable && !st_reg.update_request_source && swReinit
    |=> updFlag)
    else $error("software reinit did not set update flag");
  a_upd_trig: assert property (!st_reg.update_disable && !st_reg.update_request_source && trigReinit
    |=> updFlag)
    else $error("trigger reinit did not set update flag");
  a_irq_flag: assert property ((flagVec & st_reg.enable) != 16'h0000
    |=> irq)
    else $error("enabled flag raised no interrupt");

  // event generate writes become one-cycle request pulses; a held pulse
  // would set the update flag twice and confuse the counter side
  sequence s_ug_write;
    write && !waitrequest && address == `OFS_EVGEN
      && byteenable[0] && writedata[`B_UG];
  endsequence

  a_ug_pulse: assert property (s_ug_write |=> updateGenerate)
    else $error("update generate write made no pulse");
  a_ug_single: assert property (updateGenerate |=> !updateGenerate)
    else $error("update generate pulse lasted too long");

  // trigger edge detection outside gated mode
  a_trig_rise: assert property (!isGated && $rose(trigInput)
    |=> trigFlag)
    else $error("rising trigger edge not flagged");
  a_trig_fall: assert property (!isGated && $fell(trigInput) && !trigFlag
    && !st_reg.tgPulse |=> !trigFlag)
    else $error("falling trigger edge flagged outside gated mode");

  // event sources that must reach their flag unless updates are disabled or counting is center-aligned
  a_upd_wrap: assert property (!st_reg.update_disable && repWrap
    |=> updFlag)
    else $error("repetition wrap did not set update flag");
  a_cmp_match: assert property (cmpMatch[0] && !chInputMode[0]
    && !centerAligned |=> chFlag[0])
    else $error("compare match not flagged");
  a_cap_set: assert property (captureEvt[3] && chInputMode[3]
    |=> chFlag[3])
    else $error("capture not flagged");

  // hardware never clears an overcapture flag on its own
  a_ovc_hold: assert property (ovcFlag[1]
    && !(write && !waitrequest && address == `OFS_FLAGS) |=> ovcFlag[1])
    else $error("overcapture flag lost without a write");

  // interrupt drops once no enabled flag remains
  a_irq_quiet: assert property ((flagVec & st_reg.enable) == 16'h0000
    |=> !irq)
    else $error("interrupt without an enabled flag");

  // upper half of every register reads zero
  a_rd_upper: assert property (readdata[31:16] == 16'h0000)
    else $error("upper read data nonzero");
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// Purpose: self-checking bench of the timer status flag block
// Assumes: one wait cycle per bus access, events as one-cycle strobes
// Notes: inputs change just after the rising edge by non-blocking assignment
`timescale 1ns/1ps
`default_nettype none
`include "timer_flags_cfg.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("Error at %0t ns: got %h expected %h", $time, (g), (e)); end end
module tb_top;
  logic        clk_sys;
  logic        nrst;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [2:0]  slaveMode;
  logic        trigInput;
  logic        repWrap;
  logic        swReinit;
  logic        trigReinit;
  logic        centerAligned;
  logic [3:0]  chInputMode;
  logic [3:0]  cmpMatch;
  logic [3:0]  captureEvt;
  logic [3:0]  captureRead;
  logic        irq;
  logic        updateGenerate;
  logic        triggerGenerate;
  logic [31:0] rdata;
  logic [31:0] ctrlTab [3] = '{32'h2, 32'h4, 32'h0};
  int          n_errors;
  int          cmp_count;
  int          ugCount;
  int          tgCount;

  timer_status_flags dut (.clk_sys, .nrst, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .slaveMode, .trigInput, .repWrap,
    .swReinit, .trigReinit, .centerAligned, .chInputMode, .cmpMatch, .captureEvt,
    .captureRead, .irq, .updateGenerate, .triggerGenerate);

  // 40 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // count request pulses; each must last exactly one cycle
  always @(posedge clk_sys)
  begin
    if (updateGenerate === 1'b1) ugCount++;
    if (triggerGenerate === 1'b1) tgCount++;
  end

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_sys);
  endtask

  // hold the request until waitrequest is sampled low, bounded
  task automatic bus_wait;
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) n_errors++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= 1'b1;
    bus_wait;
    write <= 1'b0;
    tick;
  endtask

  // extra edge after release keeps back-to-back calls off one time step
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    address <= a;
    byteenable <= 4'hF;
    read <= 1'b1;
    bus_wait;
    rdata = readdata;
    read <= 1'b0;
    tick;
    `CHK(rdata, e)
  endtask

  task automatic results;
    if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under a thousand cycles
  initial
  begin
    tick(5000);
    n_errors++;
    results;
  end

  initial
  begin
    {nrst, read, write, trigInput, repWrap, swReinit, trigReinit, centerAligned} = 8'h00;
    {address, writedata, byteenable} = 44'h0;
    {chInputMode, cmpMatch, captureEvt, captureRead} = 16'h0;
    slaveMode = timer_flags_pkg::SM_TRIGGER;
    tick(20);
    nrst <= 1'b1;
    tick;
    rd(`OFS_FLAGS, 32'h0);
    rd(`OFS_ENABLE, 32'h0);
    wr(`OFS_FLAGS, 32'hFFFF_FFFF, 4'hF);
    rd(`OFS_FLAGS, 32'h0);
    wr(8'h04, 32'hFFFF_FFFF, 4'hF);
    rd(8'h04, 32'h0);
    wr(`OFS_ENABLE, 32'hFFFF_FFFF, 4'hF);
    rd(`OFS_ENABLE, 32'h5F);
    // update flag, interrupt follows one edge later
    repWrap <= 1'b1;
    tick;
    repWrap <= 1'b0;
    tick(2);
    `CHK(irq, 1'b1)
    rd(`OFS_FLAGS, 32'h1);
    wr(`OFS_FLAGS, 32'hFFFE, 4'h3);
    rd(`OFS_FLAGS, 32'h0);
    `CHK(irq, 1'b0)
    // a wrap held across a clearing write must survive it
    repWrap <= 1'b1;
    wr(`OFS_FLAGS, 32'h0, 4'hF);
    repWrap <= 1'b0;
    rd(`OFS_FLAGS, 32'h1);
    wr(`OFS_FLAGS, 32'h0, 4'hF);
    // every update source with updates disabled, with request source set, and with neither
    for (int c = 0; c < 3; c++)
    begin
      wr(`OFS_CTRL, ctrlTab[c], 4'hF);
      for (int s = 0; s < 4; s++)
      begin
        case (s)
          0: repWrap <= 1'b1;
          1: swReinit <= 1'b1;
          2: trigReinit <= 1'b1;
          default: wr(`OFS_EVGEN, 32'h1, 4'hF);
        endcase
        tick;
        {repWrap, swReinit, trigReinit} <= 3'h0;
        tick;
        rd(`OFS_FLAGS, {31'h0, ctrlTab[c] == 32'h0 || (s == 0 && !ctrlTab[c][1])});
        wr(`OFS_FLAGS, 32'h0, 4'hF);
      end
    end
    `CHK(ugCount, 3)
    // trigger edges: rising only, then the falling edge in gated mode
    trigInput <= 1'b1;
    tick(2);
    rd(`OFS_FLAGS, 32'h40);
    wr(`OFS_FLAGS, 32'h0, 4'hF);
    trigInput <= 1'b0;
    tick(2);
    rd(`OFS_FLAGS, 32'h0);
    slaveMode <= timer_flags_pkg::SM_GATED;
    tick;
    trigInput <= 1'b1;
    tick(2);
    wr(`OFS_FLAGS, 32'h0, 4'hF);
    trigInput <= 1'b0;
    tick(2);
    rd(`OFS_FLAGS, 32'h40);
    wr(`OFS_FLAGS, 32'h0, 4'hF);
    wr(`OFS_EVGEN, 32'h40, 4'hF);
    tick;
    rd(`OFS_FLAGS, 32'h40);
    `CHK(tgCount, 1)
    wr(`OFS_FLAGS, 32'h0, 4'hF);
    // output compare channels; captures and center-aligned matches ignored
    for (int i = 0; i < 4; i++)
    begin
      cmpMatch <= 4'h1 << i;
      tick;
      cmpMatch <= 4'h0;
      rd(`OFS_FLAGS, 32'h2 << i);
      wr(`OFS_FLAGS, 32'h0, 4'hF);
    end
    centerAligned <= 1'b1;
    cmpMatch <= 4'hF;
    captureEvt <= 4'hF;
    tick(2);
    {cmpMatch, captureEvt, centerAligned} <= 9'h0;
    rd(`OFS_FLAGS, 32'h0);
    // input capture channels: flag, overcapture, read clear, lane gating
    chInputMode <= 4'hF;
    cmpMatch <= 4'hF;
    tick;
    cmpMatch <= 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      captureEvt <= 4'h1 << i;
      tick;
      captureEvt <= 4'h0;
      rd(`OFS_FLAGS, 32'h2 << i);
      captureEvt <= 4'h1 << i;
      tick;
      captureEvt <= 4'h0;
      captureRead <= 4'h1 << i;
      tick;
      captureRead <= 4'h0;
      rd(`OFS_FLAGS, 32'h200 << i);
      wr(`OFS_FLAGS, 32'h0, 4'h1);
      rd(`OFS_FLAGS, 32'h200 << i);
      wr(`OFS_FLAGS, 32'h0, 4'h2);
      rd(`OFS_FLAGS, 32'h0);
    end
    // capture and capture read in one cycle: the set wins
    {captureEvt, captureRead} <= 8'h11;
    tick;
    {captureEvt, captureRead} <= 8'h11;
    tick;
    {captureEvt, captureRead} <= 8'h00;
    rd(`OFS_FLAGS, 32'h202);
    // flags set but all enables off: no interrupt
    wr(`OFS_ENABLE, 32'h0, 4'hF);
    tick(2);
    `CHK(irq, 1'b0)
    results;
  end
endmodule
`undef CHK
`default_nettype wire
